// File: core/tmv_pkg.sv
//==============================================================
`default_nettype none

package tmv_pkg;
    // register map
    localparam logic [11:0] TMV_TCS_OFFSET  = 12'h000;  // timer_control_status
    localparam int          TMV_ADDR_W      = 12;       // apb address width
    // field positions in timer_control_status
    localparam int          TMV_BIT_MATCH_B = 7;
    localparam int          TMV_BIT_MATCH_A = 6;
    localparam int          TMV_BIT_WRAP    = 5;
    localparam int          TMV_BIT_RSVD    = 4;
    localparam int          TMV_BIT_OS_HI   = 3;
    localparam int          TMV_BIT_OS_LO   = 2;
    // counter limits for wrap detection
    localparam logic [7:0]  TMV_CNT_MAX     = 8'hFF;
    localparam logic [7:0]  TMV_CNT_ZERO    = 8'h00;
    // values after reset
    localparam logic [2:0]  TMV_FLAGS_RST   = 3'h0;
    localparam logic [1:0]  TMV_OS_RST      = 2'h0;
    localparam logic        TMV_PIN_RST     = 1'b0;

    // output action on compare match B
    typedef enum logic [1:0] {
        TMV_OS_HOLD   = 2'b00,
        TMV_OS_LOW    = 2'b01,
        TMV_OS_HIGH   = 2'b10,
        TMV_OS_TOGGLE = 2'b11
    } tmv_os_e;
endpackage : tmv_pkg

`default_nettype wire

// File: core/tmv_flags.sv
// Added by the designer: the APB interface to the registers and the address map.
`default_nettype none

module tmv_flags (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [tmv_pkg::TMV_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [7:0]                    timer_count,
    input  wire logic [7:0]                    compare_a_value,
    input  wire logic [7:0]                    compare_b_value,
    output logic                               timer_out_pin
);
    import tmv_pkg::*;

    //==========================================================
    // state
    //==========================================================
    logic [2:0] flags;      // {match_b_flag, match_a_flag, wrap_flag}
    logic [2:0] armed;      // flag was read as 1 since last write
    logic [1:0] out_select; // {out_select_hi, out_select_lo}
    logic       eq_a_q;     // previous-cycle equality, A
    logic       eq_b_q;     // previous-cycle equality, B
    logic [7:0] count_q;    // previous counter value

    //==========================================================
    // apb decode
    //==========================================================
    wire        access   = psel & penable & ~pready;  // access phase, answer next
    wire        done     = psel & penable & pready;   // completing edge
    wire        hit      = (paddr == TMV_TCS_OFFSET);
    wire        wr_done  = done & pwrite & hit;
    wire        rd_done  = done & ~pwrite & hit;
    // status byte as read; low bits unused read zero
    wire [7:0]  status_byte = {flags, 1'b1, out_select, 2'b00};

    //==========================================================
    // events
    //==========================================================
    wire        eq_a     = (timer_count == compare_a_value);
    wire        eq_b     = (timer_count == compare_b_value);
    wire        ev_a     = eq_a & ~eq_a_q;
    wire        ev_b     = eq_b & ~eq_b_q;
    wire        ev_wrap  = (count_q == TMV_CNT_MAX) & (timer_count == TMV_CNT_ZERO);
    wire [2:0]  events   = {ev_b, ev_a, ev_wrap};
    wire [2:0]  wr_flags = pwdata[TMV_BIT_MATCH_B:TMV_BIT_WRAP];
    // clear only a flag armed by a 1-read, written 0
    wire [2:0]  clr      = {3{wr_done}} & armed & ~wr_flags;
    // set beats clear in the same cycle
    wire [2:0]  next_flags = events | (flags & ~clr);

    function automatic logic pin_action(input logic [1:0] sel, input logic cur);
        case (sel)
            TMV_OS_HOLD:   pin_action = cur;
            TMV_OS_LOW:    pin_action = 1'b0;
            TMV_OS_HIGH:   pin_action = 1'b1;
            TMV_OS_TOGGLE: pin_action = ~cur;
            default:       pin_action = cur;
        endcase
    endfunction : pin_action

    wire        next_pin = ev_b ? pin_action(out_select, timer_out_pin) : timer_out_pin;

    //==========================================================
    // event history
    //==========================================================
    // equality kept one cycle so a match sets once, not each cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eq_a_q  <= 1'b1;
            eq_b_q  <= 1'b1;
            count_q <= TMV_CNT_ZERO;
        end
        else
        begin
            eq_a_q  <= eq_a;
            eq_b_q  <= eq_b;
            count_q <= timer_count;
        end
    end

    //==========================================================
    // flags and arming
    //==========================================================
    // flags reset to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= TMV_FLAGS_RST;
            armed <= TMV_FLAGS_RST;
        end
        else
        begin
            flags <= next_flags;
            // read arms the clear
            // any write to timer_control_status ends the read-then-clear sequence
            if (wr_done)
                armed <= 3'h0;
            else if (rd_done)
                armed <= armed | prdata[TMV_BIT_MATCH_B:TMV_BIT_WRAP];
        end
    end

    //==========================================================
    // output select and pin
    //==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_select    <= TMV_OS_RST;
            timer_out_pin <= TMV_PIN_RST;
        end
        else
        begin
            if (wr_done)
                out_select <= pwdata[TMV_BIT_OS_HI:TMV_BIT_OS_LO];
            // pin updates on match B only
            timer_out_pin <= next_pin;
        end
    end

    //==========================================================
    // apb answer: one wait state, registered
    //==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= access;
            pslverr <= access & ~hit;
            // reserved bit comes back as one
            if (access & ~pwrite & hit)
                prdata <= {24'h00_0000, status_byte};
            else
                prdata <= 32'h0000_0000;
        end
    end

    //==========================================================
    // checks
    //==========================================================
    // read of a one arms that flag's clear
    sequence s_read_b_one;
        rd_done && prdata[TMV_BIT_MATCH_B];
    endsequence
    sequence s_read_a_one;
        rd_done && prdata[TMV_BIT_MATCH_A];
    endsequence
    // armed zero-write, no event in the same cycle
    sequence s_write_b_zero;
        wr_done && armed[2] && !pwdata[TMV_BIT_MATCH_B] && !ev_b;
    endsequence
    sequence s_write_a_zero;
        wr_done && armed[1] && !pwdata[TMV_BIT_MATCH_A] && !ev_a;
    endsequence
    sequence s_write_wrap_zero;
        wr_done && armed[0] && !pwdata[TMV_BIT_WRAP] && !ev_wrap;
    endsequence

    AST_MATCH_B_SET: assert property (@(posedge pclk) disable iff (!presetn)
        ev_b |=> flags[2]) else $error("match b flag not set");
    AST_MATCH_B_ARM: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_b_one |=> armed[2]) else $error("match b flag not armed by read");
    AST_MATCH_B_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_b_zero |=> !flags[2]) else $error("match b flag not cleared");
    AST_MATCH_B_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        flags[2] && !armed[2] |=> flags[2]) else $error("match b flag lost without read");
    AST_MATCH_B_NO_SET: assert property (@(posedge pclk) disable iff (!presetn)
        !flags[2] && !ev_b |=> !flags[2]) else $error("match b flag set without match");

    AST_MATCH_A_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_count == compare_a_value) && !$past(timer_count == compare_a_value)
        |=> flags[1]) else $error("match a flag not set");
    AST_MATCH_A_ARM: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_a_one |=> armed[1]) else $error("match a flag not armed by read");
    AST_MATCH_A_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_a_zero |=> !flags[1]) else $error("match a flag not cleared");
    AST_MATCH_A_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        flags[1] && !(wr_done && !pwdata[TMV_BIT_MATCH_A]) |=> flags[1])
        else $error("match a flag lost");

    AST_WRAP_SET: assert property (@(posedge pclk) disable iff (!presetn)
        $past(timer_count) == 8'hFF && timer_count == 8'h00 |=> flags[0])
        else $error("wrap flag not set");
    AST_WRAP_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        s_write_wrap_zero |=> !flags[0]) else $error("wrap flag not cleared");
    AST_WRAP_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        flags[0] && !armed[0] |=> flags[0]) else $error("wrap flag lost without read");

    AST_RSVD_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && !pslverr |-> prdata[TMV_BIT_RSVD]) else $error("reserved bit read zero");
    AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        ev_a && wr_done |=> flags[1]) else $error("clear beat set");

    AST_PIN_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        ev_b && out_select == 2'b01 |=> !timer_out_pin) else $error("pin not driven low");
    AST_PIN_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        ev_b && out_select == 2'b10 |=> timer_out_pin) else $error("pin not driven high");
    AST_PIN_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        ev_b && out_select == 2'b11 |=> timer_out_pin != $past(timer_out_pin))
        else $error("pin did not toggle");
    AST_PIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !ev_b |=> $stable(timer_out_pin)) else $error("pin moved without match b");
endmodule : tmv_flags

`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tmv_pkg::*;

    // ==========================================
    // stimulus and observation nets
    logic        pclk = 1'b0;    // bus clock
    logic        presetn = 1'b0; // async reset
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  timer_count = 8'h00;
    logic [7:0]  compare_a_value = 8'h05; // match a at five
    logic [7:0]  compare_b_value = 8'h80; // match b at mid-scale
    logic        timer_out_pin;
    logic [31:0] rd;          // last read word
    logic        er;          // last error response
    logic        pin_exp;     // pin model
    logic [1:0]  codes [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;

    tmv_flags tmv_flags_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_count(timer_count), .compare_a_value(compare_a_value),
        .compare_b_value(compare_b_value), .timer_out_pin(timer_out_pin));

    // 125 MHz
    always #4 pclk = ~pclk;

    // ==========================================
    // tasks
    task finish_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; waits on pready, the global timeout cuts a hang
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // counter step, flag lands on the following edge
    task set_count(input logic [7:0] v);
        @(posedge pclk);
        timer_count <= v;
        @(posedge pclk);
    endtask : set_count

    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            finish_test();
        end
    end

    // ==========================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h10); // reset value
        // unmapped read refused with zero data
        apb(1'b0, 12'h004, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, TMV_TCS_OFFSET, 32'hFF);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h1C); // ones do not set
        set_count(8'h04);
        set_count(8'h05);
        // write disarms, so the blind zero must not clear
        apb(1'b1, TMV_TCS_OFFSET, 32'hEC);
        apb(1'b1, TMV_TCS_OFFSET, 32'h0C);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h5C); // set, blind clear held
        // armed clear completes on the edge of a new match a
        set_count(8'h04);
        fork
            apb(1'b1, TMV_TCS_OFFSET, 32'h0C);
            begin
                repeat (3) @(posedge pclk);
                timer_count <= 8'h05;
            end
        join
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h5C); // set beats clear
        apb(1'b1, TMV_TCS_OFFSET, 32'h0C);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h1C); // clear after read
        // every output action on match b, pin model starts low
        pin_exp = 1'b0;
        foreach (codes[i])
        begin
            apb(1'b1, TMV_TCS_OFFSET, {28'h0, codes[i], 2'b00});
            set_count(8'h7F);
            set_count(8'h80);
            repeat (2) @(posedge pclk);
            case (codes[i])
                2'h1: pin_exp = 1'b0;
                2'h2: pin_exp = 1'b1;
                2'h3: pin_exp = ~pin_exp;
                default: pin_exp = pin_exp;
            endcase
            check({31'h0, timer_out_pin}, {31'h0, pin_exp}); // pin action
        end
        set_count(8'hFF);
        set_count(8'h00);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'hBC); // flags b and wrap
        // unmapped write refused and ignored
        apb(1'b1, 12'h004, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'hBC); // unmapped write ignored
        apb(1'b1, TMV_TCS_OFFSET, 32'h0);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h10); // armed clear
        // match b again under hold, then a mid-run reset
        set_count(8'h7F);
        set_count(8'h80);
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h90); // match b sets again
        check({31'h0, timer_out_pin}, 32'h1); // hold keeps pin high
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check({31'h0, timer_out_pin}, 32'h0); // pin back to zero
        apb(1'b0, TMV_TCS_OFFSET, 32'h0);
        check(rd, 32'h10); // flags cleared by reset
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
